/* File: logic/rx_front_map.vh */
// Purpose: register offsets, field positions, reset values and counts of the receive front end
// Assumes: included by the receive front end files and by its testbench
// Notes:   definitions only
`ifndef RX_FRONT_MAP_VH
`define RX_FRONT_MAP_VH

// register offsets (byte addresses)
`define OFS_CTRL        8'h00
`define OFS_PATTERN     8'h04
`define OFS_RUNLEN      8'h08
`define OFS_STATUS      8'h0c

// control register fields
`define CTRL_MODE_LO    0
`define CTRL_MODE_HI    2
`define CTRL_PROTO_LO   4
`define CTRL_PROTO_HI   5
`define CTRL_WIDTH10    6
`define CTRL_DOUBLE     7
`define CTRL_USED       8
`define CTRL_PAT7       9
`define CTRL_QUAD       10
`define CTRL_PPM_LO     12
`define CTRL_PPM_HI     13
`define CTRL_RESET      32'h0000_0142

// aligner mode codes
`define MODE_SLIP       3'h0
`define MODE_A16        3'h1
`define MODE_A10        3'h2
`define MODE_XAUI       3'h3
`define MODE_GIGE       3'h4

// protocol codes
`define PROTO_CUSTOM    2'h0
`define PROTO_SONET     2'h1
`define PROTO_XAUI      2'h2
`define PROTO_GIGE      2'h3

// pattern and run length reset values, run length step units
`define PATTERN_RESET   16'h017c
`define RUNLEN_RESET    5'h1f
`define RL_UNIT10       8'h05
`define RL_UNIT8        8'h04

// frequency and phase thresholds
`define PPM_T0          11'd125
`define PPM_T1          11'd250
`define PPM_T2          11'd500
`define PPM_T3          11'd1000
`define PHASE_TOL       8'd8

// comma code group, first bit in bit 0
`define COMMA_K285      10'h17c

// sync state machine counts
`define ACQ_XAUI        3'd4
`define ACQ_GIGE        3'd3
`define LOSS_BAD        3'd4

// status register fields
`define ST_LOCK_DATA    0
`define ST_REF_LOCK     1
`define ST_SYNC         2
`define ST_PAT_DET      3
`define ST_RUNLEN       4
`define ST_MODE_ERR     5
`define ST_PWRDN        6

`endif

/* File: logic/rx_deser.v */
// Purpose: serial to parallel converter with a slip-able and alignable word boundary
// Assumes: one serial bit per clock, first bit is the least significant
// Notes:   a slip delays the boundary by exactly one bit; a slip in the boundary cycle is ignored
`timescale 1ns/1ps

module rx_deser #(
	parameter SRW = 32
) (
	// clock and reset
	input  wire            clk_i,
	input  wire            rst_n_i,
	// control
	input  wire            en_i,
	input  wire            width10_i,
	input  wire            slip_i,
	input  wire            align_i,
	// serial bit
	input  wire            bit_i,
	// parallel side
	output wire [SRW-1:0]  win_o,
	output wire            boundary_o,
	output reg  [9:0]      word_o,
	output reg             word_vld_o
);

	reg  [SRW-1:0] sr_r;
	reg  [3:0]     cnt_r;
	wire [3:0]     last;

	assign last       = width10_i ? 4'd9 : 4'd7;
	assign win_o      = sr_r;
	assign boundary_o = (cnt_r == last);

	always @(posedge clk_i) begin
		if (!rst_n_i || !en_i) begin
			sr_r       <= {SRW{1'b0}};
			cnt_r      <= 4'h0;
			word_o     <= 10'h000;
			word_vld_o <= 1'b0;
		end else begin
			sr_r       <= {bit_i, sr_r[SRW-1:1]};
			word_vld_o <= 1'b0;
			if (align_i || boundary_o) begin
				word_o     <= width10_i ? sr_r[SRW-1:SRW-10] : {2'b00, sr_r[SRW-1:SRW-8]};
				word_vld_o <= 1'b1;
				cnt_r      <= 4'h0;
			end else if (slip_i) begin
				cnt_r <= cnt_r;
			end else begin
				cnt_r <= cnt_r + 4'h1;
			end
		end
	end

endmodule // rx_deser

/* File: logic/rx_front.v */
// Purpose: receive front end: lock switchover, lock status, deserializer, word aligner
// Assumes: one serial bit per clk_i; ppm and phase deviation come from the pll detectors
// Notes:   registers over apb, zero wait states
// Notes on behaviour
// - lock-to-data input wins; reference input alone forces reference; both low is auto.
// - unconnected override inputs tied low give automatic switchover.
// - auto mode goes to data lock only within selected ppm threshold.
// - auto mode also needs phase within .08 UI before data lock.
// - status output shows the recovery unit is locked to data.
// - active-low output shows receive pll locked to reference.
// - unused channel powers down its pll and recovery unit.
// - serial stream becomes 8 or 10 bit words, first bit is lsb.
// - run length threshold 5..160 step 5, or 4..128 step 4.
// - each slip request moves the word boundary by exactly one bit. A request that falls in the boundary cycle is ignored.
// - bit-slip mode keeps pattern detection; 8/10 bit, single or double width. Only single width is built; CTRL_DOUBLE is stored, unused.
// - bit-slip only under custom or sonet protocol.
// - 16-bit mode aligns to A1A2; A1A1A2A2 only under sonet.
// - 16-bit mode realigns when the realign input is raised.
// - 16-bit mode only on 8-bit path, custom or sonet.
// - 10-bit mode aligns to pattern, full ten or lower seven bits.
// - 10-bit pattern matched in both disparities.
// - 10-bit alignment only while aligner enable input is high.
// - 10-bit mode only under custom protocol.
// - xaui and gige modes use a sync machine on comma K28.5.
// - xaui machine only for xaui protocol, gige only for gige.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "rx_front_map.vh"

module rx_front #(
	parameter SRW = 32
) (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_n_i,
	// apb slave
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [7:0]  paddr_i,
	input  wire [31:0] pwdata_i,
	output reg  [31:0] prdata_o,
	output wire        pready_o,
	output wire        pslverr_o,
	// lock overrides and pll status
	input  wire        lock_data_i,
	input  wire        lock_ref_i,
	input  wire        pll_ref_lock_i,
	input  wire [10:0] ppm_dev_i,
	input  wire [7:0]  phase_dev_i,
	// serial data and fabric controls
	input  wire        sdata_i,
	input  wire        slip_i,
	input  wire        realign_i,
	input  wire        align_en_i,
	// status and parallel data
	output reg         lock_to_data_o,
	output reg         pll_locked_n_o,
	output reg         pwrdn_o,
	output reg         pattern_det_o,
	output reg         sync_o,
	output reg         runlen_err_o,
	output wire [9:0]  word_o,
	output wire        word_vld_o
);

	localparam LK_REF  = 2'b01;
	localparam LK_DATA = 2'b10;
	localparam SY_LOSS = 3'b001;
	localparam SY_ACQ  = 3'b010;
	localparam SY_OK   = 3'b100;

	reg  [31:0]    ctrl_r;
	reg  [15:0]    pat_r;
	reg  [4:0]     rlen_r;
	reg  [1:0]     lk_r;
	reg  [1:0]     lk_nxt;
	reg  [2:0]     sy_r;
	reg  [2:0]     sy_nxt;
	reg  [2:0]     good_r;
	reg  [2:0]     good_nxt;
	reg  [2:0]     bad_r;
	reg  [2:0]     bad_nxt;
	reg            slip_d_r;
	reg            realign_d_r;
	reg            armed_r;
	reg            aligned_r;
	reg            last_bit_r;
	reg  [7:0]     run_r;
	reg            align_req;
	reg            det;
	wire [SRW-1:0] win;
	wire           boundary;
	wire [2:0]     mode;
	wire [1:0]     proto;
	wire           width10;
	wire           used;
	wire           mode_ok;
	wire           auto_ok;
	wire [9:0]     w10;
	wire [7:0]     w8;
	wire           m10;
	wire           m16;
	wire           comma;
	wire           slip_ev;
	wire           realign_ev;
	wire           setup;
	wire           mapped;
	wire           sync_mode;
	wire [31:0]    status;

	assign mode    = ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO];
	assign proto   = ctrl_r[`CTRL_PROTO_HI:`CTRL_PROTO_LO];
	assign width10 = ctrl_r[`CTRL_WIDTH10];
	assign used    = ctrl_r[`CTRL_USED];

	// frequency window for the selected ppm setting
	function [10:0] ppm_thr;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: ppm_thr = `PPM_T0;
				2'h1: ppm_thr = `PPM_T1;
				2'h2: ppm_thr = `PPM_T2;
				default: ppm_thr = `PPM_T3;
			endcase
		end
	endfunction

	// run length limit: (field + 1) steps of 5 or 4 bits
	function [7:0] rl_thr;
		input [4:0] steps;
		input       w10_path;
		reg   [7:0] unit;
		begin
			unit   = w10_path ? `RL_UNIT10 : `RL_UNIT8;
			rl_thr = ({3'b000, steps} + 8'h01) * unit;
		end
	endfunction

	// legal combinations of aligner mode, protocol and path width
	function legal;
		input [2:0] m;
		input [1:0] p;
		input       w10_path;
		input       quad;
		reg         cs;
		begin
			cs = (p == `PROTO_CUSTOM) || (p == `PROTO_SONET);
			case (m)
				`MODE_SLIP: legal = cs;
				`MODE_A16:  legal = cs && !w10_path && (!quad || p == `PROTO_SONET);
				`MODE_A10:  legal = (p == `PROTO_CUSTOM) && w10_path;
				`MODE_XAUI: legal = (p == `PROTO_XAUI) && w10_path;
				`MODE_GIGE: legal = (p == `PROTO_GIGE) && w10_path;
				default:    legal = 1'b0;
			endcase
		end
	endfunction

	assign mode_ok   = legal(mode, proto, width10, ctrl_r[`CTRL_QUAD]);
	assign sync_mode = (mode == `MODE_XAUI) || (mode == `MODE_GIGE);

	// ---------------- apb slave ----------------
	assign setup     = psel_i && !penable_i;
	assign mapped    = (paddr_i == `OFS_CTRL) || (paddr_i == `OFS_PATTERN) ||
	                   (paddr_i == `OFS_RUNLEN) || (paddr_i == `OFS_STATUS);
	assign pready_o  = psel_i && penable_i;
	assign pslverr_o = psel_i && penable_i && !mapped;

	assign status = {25'h0, pwrdn_o, !mode_ok, runlen_err_o, pattern_det_o, sync_o,
	                 pll_ref_lock_i && used, lock_to_data_o};

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctrl_r   <= `CTRL_RESET;
			pat_r    <= `PATTERN_RESET;
			rlen_r   <= `RUNLEN_RESET;
			prdata_o <= 32'h0000_0000;
		end else begin
			if (setup && !pwrite_i) begin
				case (paddr_i)
					`OFS_CTRL:    prdata_o <= ctrl_r;
					`OFS_PATTERN: prdata_o <= {16'h0000, pat_r};
					`OFS_RUNLEN:  prdata_o <= {27'h0, rlen_r};
					`OFS_STATUS:  prdata_o <= status;
					default:      prdata_o <= 32'h0000_0000;
				endcase
			end
			if (pready_o && pwrite_i) begin
				case (paddr_i)
					`OFS_CTRL:    ctrl_r <= pwdata_i & 32'h0000_37f7;
					`OFS_PATTERN: pat_r <= pwdata_i[15:0];
					`OFS_RUNLEN:  rlen_r <= pwdata_i[4:0];
					default:      ctrl_r <= ctrl_r;
				endcase
			end
		end
	end

	// ---------------- lock switchover ----------------
	assign auto_ok = (ppm_dev_i <= ppm_thr(ctrl_r[`CTRL_PPM_HI:`CTRL_PPM_LO])) &&
	                 (phase_dev_i <= `PHASE_TOL);

	always @* begin
		lk_nxt = lk_r;
		if (!used) begin
			lk_nxt = LK_REF;
		end else if (lock_data_i) begin
			lk_nxt = LK_DATA;
		end else if (lock_ref_i) begin
			lk_nxt = LK_REF;
		end else begin
			case (lk_r)
				LK_REF: begin
					if (auto_ok)
						lk_nxt = LK_DATA;
				end
				LK_DATA: begin
					if (ppm_dev_i > ppm_thr(ctrl_r[`CTRL_PPM_HI:`CTRL_PPM_LO]))
						lk_nxt = LK_REF;
				end
				default: lk_nxt = LK_REF;
			endcase
		end
	end

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			lk_r           <= LK_REF;
			lock_to_data_o <= 1'b0;
			pll_locked_n_o <= 1'b1;
			pwrdn_o        <= 1'b0;
		end else begin
			lk_r           <= lk_nxt;
			lock_to_data_o <= (lk_nxt == LK_DATA);
			pll_locked_n_o <= !(pll_ref_lock_i && used);
			pwrdn_o        <= !used;
		end
	end

	// ---------------- pattern compare ----------------
	assign w10   = win[SRW-1:SRW-10];
	assign w8    = win[SRW-1:SRW-8];
	assign m10   = ctrl_r[`CTRL_PAT7] ?
	               ((w10[6:0] == pat_r[6:0]) || (w10[6:0] == ~pat_r[6:0])) :
	               ((w10 == pat_r[9:0]) || (w10 == ~pat_r[9:0]));
	assign m16   = ctrl_r[`CTRL_QUAD] ?
	               (win == {pat_r[15:8], pat_r[15:8], pat_r[7:0], pat_r[7:0]}) :
	               (win[SRW-1:SRW-16] == pat_r);
	assign comma = (w10 == `COMMA_K285) || (w10 == ~`COMMA_K285);

	assign slip_ev    = slip_i && !slip_d_r;
	assign realign_ev = realign_i && !realign_d_r;

	// ---------------- comma sync machine ----------------
	always @* begin
		sy_nxt   = sy_r;
		good_nxt = good_r;
		bad_nxt  = bad_r;
		case (sy_r)
			SY_LOSS: begin
				if (comma) begin
					sy_nxt   = SY_ACQ;
					good_nxt = 3'd1;
				end
			end
			SY_ACQ: begin
				if (comma && boundary) begin
					good_nxt = good_r + 3'd1;
					if (good_nxt == ((mode == `MODE_XAUI) ? `ACQ_XAUI : `ACQ_GIGE)) begin
						sy_nxt  = SY_OK;
						bad_nxt = 3'd0;
					end
				end else if (comma) begin
					good_nxt = 3'd1;
				end
			end
			SY_OK: begin
				if (comma && !boundary) begin
					bad_nxt = bad_r + 3'd1;
					if (bad_nxt == `LOSS_BAD)
						sy_nxt = SY_LOSS;
				end else if (comma) begin
					bad_nxt = 3'd0;
				end
			end
			default: sy_nxt = SY_LOSS;
		endcase
		if (!sync_mode || !mode_ok) begin
			sy_nxt   = SY_LOSS;
			good_nxt = 3'd0;
			bad_nxt  = 3'd0;
		end
	end

	// ---------------- aligner control ----------------
	always @* begin
		align_req = 1'b0;
		det       = 1'b0;
		if (mode_ok) begin
			case (mode)
				`MODE_SLIP: begin
					det = boundary && (width10 ? (w10 == pat_r[9:0]) : (w8 == pat_r[7:0]));
				end
				`MODE_A16: begin
					det       = m16;
					align_req = m16 && armed_r;
				end
				`MODE_A10: begin
					det       = m10;
					align_req = m10 && align_en_i;
				end
				`MODE_XAUI, `MODE_GIGE: begin
					det       = comma;
					align_req = comma && (sy_r != SY_OK);
				end
				default: begin
					det       = 1'b0;
					align_req = 1'b0;
				end
			endcase
		end
	end

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			sy_r          <= SY_LOSS;
			good_r        <= 3'd0;
			bad_r         <= 3'd0;
			slip_d_r      <= 1'b0;
			realign_d_r   <= 1'b0;
			armed_r       <= 1'b1;
			aligned_r     <= 1'b0;
			pattern_det_o <= 1'b0;
			sync_o        <= 1'b0;
		end else begin
			sy_r          <= sy_nxt;
			good_r        <= good_nxt;
			bad_r         <= bad_nxt;
			slip_d_r      <= slip_i;
			realign_d_r   <= realign_i;
			pattern_det_o <= det;
			// a match moves the boundary in the deserializer, so it wins over a re-arm
			if (align_req) begin
				armed_r   <= 1'b0;
				aligned_r <= 1'b1;
			end else if (realign_ev || !mode_ok) begin
				armed_r   <= 1'b1;
				aligned_r <= 1'b0;
			end
			sync_o <= sync_mode ? (sy_nxt == SY_OK) : (aligned_r || align_req);
		end
	end

	// ---------------- run length detector ----------------
	always @(posedge clk_i) begin
		if (!rst_n_i || !used) begin
			last_bit_r   <= 1'b0;
			run_r        <= 8'h00;
			runlen_err_o <= 1'b0;
		end else begin
			last_bit_r <= sdata_i;
			if (sdata_i != last_bit_r)
				run_r <= 8'h01;
			else if (run_r != 8'hff)
				run_r <= run_r + 8'h01;
			runlen_err_o <= (sdata_i == last_bit_r) && (run_r >= rl_thr(rlen_r, width10));
		end
	end

	rx_deser #(
		.SRW (SRW)
	) u_deser (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.en_i       (used),
		.width10_i  (width10),
		.slip_i     (slip_ev && mode_ok && mode == `MODE_SLIP),
		.align_i    (align_req),
		.bit_i      (sdata_i),
		.win_o      (win),
		.boundary_o (boundary),
		.word_o     (word_o),
		.word_vld_o (word_vld_o)
	);

endmodule // rx_front

/* File: testbench/rx_front_asserts.sv */
// Purpose: port checker for the receive front end
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to rx_front after the module
`timescale 1ns/1ps
module rx_front_asserts (
	// clock, reset and apb
	input wire        clk_i,
	input wire        rst_n_i,
	input wire        psel_i,
	input wire        penable_i,
	input wire [7:0]  paddr_i,
	input wire        pready_o,
	input wire        pslverr_o,
	// lock, status and words
	input wire        lock_data_i,
	input wire        lock_ref_i,
	input wire        pll_ref_lock_i,
	input wire [10:0] ppm_dev_i,
	input wire [7:0]  phase_dev_i,
	input wire        lock_to_data_o,
	input wire        pll_locked_n_o,
	input wire        pwrdn_o,
	input wire        word_vld_o
);
	wire auto_mode;
	assign auto_mode = !lock_data_i && !lock_ref_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_apb_ready: assert property (psel_i && penable_i |-> pready_o)
		else $error("wait state inserted");
	a_apb_err: assert property (psel_i && penable_i && paddr_i > 8'h0c |-> pslverr_o)
		else $error("unmapped access not flagged");
	a_data_force: assert property (lock_data_i && !pwrdn_o |=> lock_to_data_o || pwrdn_o)
		else $error("data lock not forced");
	a_ref_force: assert property (!lock_data_i && lock_ref_i |=> !lock_to_data_o)
		else $error("reference lock not forced");
	a_ppm_exceed: assert property (auto_mode && ppm_dev_i > 11'h3e8 |=> !lock_to_data_o)
		else $error("data lock outside ppm window");
	a_phase_wait: assert property (auto_mode && phase_dev_i > 8'h08 && !lock_to_data_o
		|=> !lock_to_data_o)
		else $error("data lock with phase error");
	a_pwrdn_ref: assert property (pwrdn_o ##1 pwrdn_o |-> !lock_to_data_o)
		else $error("unused channel locked to data");
	a_ref_lock: assert property (pll_ref_lock_i && !pwrdn_o |=> !pll_locked_n_o || pwrdn_o)
		else $error("lock status not shown");
	a_ref_unlock: assert property (!pll_ref_lock_i |=> pll_locked_n_o)
		else $error("lock shown while unlocked");
	a_word_rate: assert property (word_vld_o && !pwrdn_o |-> ##[1:12] (word_vld_o || pwrdn_o))
		else $error("word stream stalled");
endmodule // rx_front_asserts

bind rx_front rx_front_asserts i_chk (
	.clk_i, .rst_n_i, .psel_i, .penable_i, .paddr_i, .pready_o, .pslverr_o,
	.lock_data_i, .lock_ref_i, .pll_ref_lock_i, .ppm_dev_i, .phase_dev_i,
	.lock_to_data_o, .pll_locked_n_o, .pwrdn_o, .word_vld_o
);

/* File: testbench/tx_model.sv */
// Purpose: remote serial transmitter driving the receive line
// Assumes: one bit per clock, bit 0 of a word goes first
// Notes:   idle line toggles so no stale level stands
`timescale 1ns/1ps
module tx_model (
	// clock
	input  wire clk_i,
	// serial line
	output reg  sdata_o
);
	bit q[$];
	initial sdata_o = 1'b0;
	task automatic send(input logic [9:0] w);
		for (int i = 0; i < 10; i++)
			q.push_back(w[i]);
	endtask
	task clear;
		q.delete();
	endtask
	always @(posedge clk_i) begin
		if (q.size() != 0)
			sdata_o <= q.pop_front();
		else
			sdata_o <= ~sdata_o;
	end
endmodule // tx_model

/* File: testbench/tb.sv */
// Purpose: self-checking bench for the receive front end
// Assumes: apb and fabric controls driven here, serial line by tx_model
// Notes:   words are checked against a queue of expected values
`timescale 1ns/1ps
`include "rx_front_map.vh"
module tb;
	// design inputs
	reg         clk_i = 1'b0;
	reg         rst_n_i = 1'b0;
	reg         psel_i = 1'b0;
	reg         penable_i = 1'b0;
	reg         pwrite_i = 1'b0;
	reg  [7:0]  paddr_i = 8'h00;
	reg  [31:0] pwdata_i = 32'h0;
	reg         lock_data_i = 1'b0;
	reg         lock_ref_i = 1'b0;
	reg         pll_ref_lock_i = 1'b0;
	reg  [10:0] ppm_dev_i = 11'h0;
	reg  [7:0]  phase_dev_i = 8'h0;
	reg         slip_i = 1'b0;
	reg         realign_i = 1'b0;
	reg         align_en_i = 1'b0;
	// design outputs
	wire [31:0] prdata_o;
	wire [9:0]  word_o;
	wire        pready_o, pslverr_o, lock_to_data_o, pll_locked_n_o, pwrdn_o;
	wire        pattern_det_o, sync_o, runlen_err_o, word_vld_o, sdata;
	// bench state
	integer     num_errors = 0;
	integer     n_checks = 0;
	integer     seed = 32'h7a26;
	reg  [31:0] rdata;
	reg         armed = 1'b0;
	reg  [9:0]  pat = 10'h000;
	reg  [9:0]  exp_q[$];

	always #25 clk_i = ~clk_i;

	rx_front #(.SRW(32)) i_dut (
		.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .lock_data_i, .lock_ref_i, .pll_ref_lock_i,
		.ppm_dev_i, .phase_dev_i, .sdata_i(sdata), .slip_i, .realign_i,
		.align_en_i, .lock_to_data_o, .pll_locked_n_o, .pwrdn_o, .pattern_det_o,
		.sync_o, .runlen_err_o, .word_o, .word_vld_o
	);
	tx_model i_tx (.clk_i, .sdata_o(sdata));

	task check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task fail_to;
		$display("[FAIL] %0t wait expired", $time);
		num_errors++;
		finish_test;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		integer n;
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 16);
		if (pready_o !== 1'b1)
			fail_to;
		rdata = prdata_o;
		if (a > `OFS_STATUS)
			check(pslverr_o, 1'b1);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// leave data lock first so auto mode must earn it again
	task auto_try(input logic e);
		lock_ref_i <= 1'b1;
		@(posedge clk_i);
		lock_ref_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		check(lock_to_data_o, e);
	endtask
	task slip_once;
		slip_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		slip_i <= 1'b0;
		repeat (24) @(posedge clk_i);
	endtask
	task drain;
		integer n;
		for (n = 0; n < 600 && exp_q.size() > 0; n++)
			@(posedge clk_i);
		if (exp_q.size() > 0)
			fail_to;
	endtask
	// two-bit symbols keep data free of comma-like runs
	function automatic [9:0] manch(input [4:0] r);
		for (int j = 0; j < 5; j++)
			manch[2*j +: 2] = {~r[j], r[j]};
	endfunction

	always @(posedge clk_i) begin
		if (word_vld_o === 1'b1 && exp_q.size() > 0) begin
			if (armed)
				check(word_o, exp_q.pop_front());
			else if (word_o === pat)
				armed <= 1'b1;
		end
	end

	initial begin : main
		integer i, k, p, r;
		reg [10:0] thr [0:3];
		reg [11:0] ctl [0:12];
		reg [12:0] errs;
		thr = '{`PPM_T0, `PPM_T1, `PPM_T2, `PPM_T3};
		ctl = '{12'h000, 12'h010, 12'h020, 12'h011, 12'h051, 12'h021, 12'h401,
			12'h411, 12'h052, 12'h042, 12'h063, 12'h073, 12'h074};
		errs = 13'h0974;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		apb(1'b0, `OFS_CTRL, 32'h0);
		check(rdata, `CTRL_RESET);
		apb(1'b0, `OFS_PATTERN, 32'h0);
		check(rdata, {16'h0, `PATTERN_RESET});
		apb(1'b0, 8'h10, 32'h0);
		check(rdata, 32'h0);
		for (i = 0; i < 4; i++) begin
			apb(1'b1, `OFS_CTRL, `CTRL_RESET | (i << `CTRL_PPM_LO));
			ppm_dev_i <= thr[i];
			phase_dev_i <= `PHASE_TOL;
			auto_try(1'b1);
			ppm_dev_i <= thr[i] + 11'h1;
			repeat (3) @(posedge clk_i);
			check(lock_to_data_o, 1'b0);
			auto_try(1'b0);
		end
		for (i = 0; i < 8; i++) begin
			p = {$random(seed)} % 1100;
			r = {$random(seed)} % 16;
			ppm_dev_i <= p[10:0];
			phase_dev_i <= r[7:0];
			auto_try(p <= `PPM_T3 && r <= `PHASE_TOL);
		end
		lock_data_i <= 1'b1;
		lock_ref_i <= p[0];
		ppm_dev_i <= 11'h7d0;
		repeat (3) @(posedge clk_i);
		check(lock_to_data_o, 1'b1);
		lock_data_i <= 1'b0;
		lock_ref_i <= 1'b1;
		ppm_dev_i <= 11'h0;
		phase_dev_i <= 8'h0;
		repeat (3) @(posedge clk_i);
		check(lock_to_data_o, 1'b0);
		lock_ref_i <= 1'b0;
		pll_ref_lock_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		check(lock_to_data_o, 1'b1);
		check(pll_locked_n_o, 1'b0);
		pll_ref_lock_i <= 1'b0;
		apb(1'b1, `OFS_CTRL, 32'h42);
		apb(1'b0, `OFS_STATUS, 32'h0);
		check(rdata[`ST_PWRDN], 1'b1);
		check({pwrdn_o, lock_to_data_o, pll_locked_n_o}, 3'h5);
		for (i = 0; i < 13; i++) begin
			apb(1'b1, `OFS_CTRL, {20'h0, ctl[i]} | 32'h100);
			apb(1'b0, `OFS_STATUS, 32'h0);
			check(rdata[`ST_MODE_ERR], errs[i]);
		end
		align_en_i <= 1'b1;
		for (i = 0; i < 3; i++) begin
			apb(1'b1, `OFS_CTRL, i == 2 ? 32'h342 : `CTRL_RESET);
			pat <= i == 0 ? `COMMA_K285 : (i == 1 ? 10'h283 : 10'h37c);
			armed <= 1'b0;
			@(posedge clk_i);
			i_tx.send(pat);
			for (k = 0; k < 6; k++) begin
				r = $random(seed);
				exp_q.push_back(manch(r[4:0]));
				i_tx.send(exp_q[k]);
			end
			drain;
		end
		apb(1'b1, `OFS_CTRL, 32'h140);
		for (k = 0; k < 60; k++)
			i_tx.send(10'h01b);
		for (k = 0; k < 11 && word_o !== 10'h01b; k++)
			slip_once;
		check(word_o, 10'h01b);
		slip_once;
		check(word_o, 10'h20d);
		i_tx.clear;
		// 16-bit mode on a ones-then-zeros pattern, short run length limit
		apb(1'b1, `OFS_PATTERN, 32'h00ff);
		apb(1'b1, `OFS_RUNLEN, 32'h0);
		apb(1'b1, `OFS_CTRL, 32'h101);
		for (i = 0; i < 2; i++) begin
			i_tx.send(10'h3ff);
			i_tx.send(10'h3ff);
			i_tx.send(10'h000);
			repeat (20) @(posedge clk_i);
			check(runlen_err_o, 1'b1);
			repeat (40) @(posedge clk_i);
			check(sync_o, 1'b1);
			check(runlen_err_o, 1'b0);
			realign_i <= 1'b1;
			repeat (3) @(posedge clk_i);
			check(sync_o, 1'b0);
			realign_i <= 1'b0;
		end
		for (i = 0; i < 2; i++) begin
			rst_n_i <= 1'b0;
			repeat (2) @(posedge clk_i);
			rst_n_i <= 1'b1;
			@(posedge clk_i);
			apb(1'b1, `OFS_CTRL, i ? 32'h174 : 32'h163);
			k = i ? `ACQ_GIGE : `ACQ_XAUI;
			for (p = 0; p < k; p++) begin
				r = $random(seed);
				i_tx.send(`COMMA_K285);
				i_tx.send(manch(r[4:0]));
			end
			repeat (20 * k - 15) @(posedge clk_i);
			check(sync_o, 1'b0);
			repeat (40) @(posedge clk_i);
			check(sync_o, 1'b1);
		end
		finish_test;
	end
endmodule // tb
